// ### wtf_pkg.sv
// Package for the wake-up timer: offsets, fields, reset values, types.
package wtf_pkg;

  // ==========================================================
  // Register map (byte addresses on the plain register port)
  localparam logic [7:0] ADDR_CONTROL = 8'h23;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'h24;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'h25;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h26;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h27;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h31;

  // ==========================================================
  // Control fields
  localparam int BIT_RUNNING = 7;
  localparam int BIT_PERMIT = 6;
  localparam int BIT_TRIM = 5;
  localparam int BIT_CARD = 4;
  localparam int BIT_RESTART = 3;
  localparam int BIT_WAKE = 2;
  localparam int CLKSEL_LSB = 0;

  // Interrupt status bits
  localparam int IRQ_UNDERFLOW = 0;
  localparam int IRQ_CARD_FOUND = 1;
  localparam int IRQ_CARD_ABSENT = 2;
  localparam int IRQ_WIDTH = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RST = 3'h0;

  // Divider ratios for input clock select 00b..11b
  localparam logic [5:0] DIV_1 = 6'h01;
  localparam logic [5:0] DIV_8 = 6'h08;
  localparam logic [5:0] DIV_16 = 6'h10;
  localparam logic [5:0] DIV_32 = 6'h20;

  typedef enum logic [1:0] {
    CLK_UNDIV,
    CLK_DIV8,
    CLK_DIV16,
    CLK_DIV32
  } wtf_clksel_t;

  // Stored control fields (running flag kept separately)
  typedef struct packed {
    logic auto_osc_trim;
    logic auto_card_detect;
    logic auto_reload_restart;
    logic auto_wake_on_underflow;
    wtf_clksel_t input_clock_select;
  } wtf_ctrl_t;

  // Plain register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wtf_req_t;

  // Requests to the surrounding system on underflow, and power down on an absent card
  typedef struct packed {
    logic trim_start;
    logic card_detect_start;
    logic wake;
    logic power_down;
  } wtf_sys_t;

endpackage : wtf_pkg

// ### wtf_wake_timer.sv
// Wake-up timer: 16-bit down counter on a divided low-frequency oscillator tick.
//
// Contract
// - Control bit 7 reads the live running state of the timer.
// - Running flag changes on write only when permit bit 6 is set too.
// - Auto trim bit 5 launches an oscillator trim on every underflow.
// - Auto card detect bit 4 runs detection on underflow; card found raises irq.
// - No card: power down if enabled; timer restarts at once without gap.
// - Card detection uses the third timer to time the field-on window.
// - Auto restart bit 3 reloads and continues; clear stops at zero unless auto card detect bit 4 is set.
// - Interrupt flag sets on every underflow, whatever the restart setting.
// - Auto wake bit 2 leaves power down on each underflow.
// - Clock select 00/01/10/11 gives oscillator clock divided by 1/8/16/32.
// - Each start event loads the counter from the concatenated reload bytes.
// - Reload byte writes do not disturb a running countdown.
// - Upper count byte reads as a live read-only value.
// - Control byte sits at address 23h.
// - Lower count byte reads live at address 27h.
// - Underflow reactivates the system when auto wake bit 2 is set and may launch card detection.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

module wtf_wake_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Low-frequency oscillator tick, from another clock domain
  input wire logic osc_tick_async,
  // Register port
  input wire wtf_pkg::wtf_req_t req,
  output logic [7:0] rdata,
  // Card detection sequence results, same clock domain
  input wire logic card_detect_done,
  input wire logic card_present,
  // Timer three field-on window, same clock domain
  output logic field_timer_start,
  // System requests, one-cycle pulses
  output wtf_pkg::wtf_sys_t sys_req,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Oscillator tick synchroniser and edge detect
  logic tick_s1_q;
  logic tick_s2_q;
  logic tick_s3_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end else begin
      tick_s1_q <= osc_tick_async;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end
  wire logic osc_edge = tick_s2_q & ~tick_s3_q;

  // ==========================================================
  // Registers
  wtf_pkg::wtf_ctrl_t ctrl_q;
  logic running_q;
  logic [7:0] reload_hi_q;
  logic [7:0] reload_lo_q;
  logic [15:0] count_q;
  logic [5:0] div_q;
  logic [wtf_pkg::IRQ_WIDTH-1:0] irq_stat_q;
  logic [wtf_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic card_busy_q;

  // Divide ratio for a clock select code
  function automatic logic [5:0] div_ratio(input wtf_pkg::wtf_clksel_t sel);
    case (sel)
      wtf_pkg::CLK_UNDIV: div_ratio = wtf_pkg::DIV_1;
      wtf_pkg::CLK_DIV8: div_ratio = wtf_pkg::DIV_8;
      wtf_pkg::CLK_DIV16: div_ratio = wtf_pkg::DIV_16;
      wtf_pkg::CLK_DIV32: div_ratio = wtf_pkg::DIV_32;
      default: div_ratio = wtf_pkg::DIV_1;
    endcase
  endfunction : div_ratio

  // ==========================================================
  // Address decode
  wire logic wr_ctrl = req.wr && (req.addr == wtf_pkg::ADDR_CONTROL);
  wire logic wr_rhi = req.wr && (req.addr == wtf_pkg::ADDR_RELOAD_HI);
  wire logic wr_rlo = req.wr && (req.addr == wtf_pkg::ADDR_RELOAD_LO);
  wire logic wr_stat = req.wr && (req.addr == wtf_pkg::ADDR_IRQ_STATUS);
  wire logic wr_mask = req.wr && (req.addr == wtf_pkg::ADDR_IRQ_MASK);
  wire logic permit_wr = wr_ctrl && req.wdata[wtf_pkg::BIT_PERMIT];
  wire logic start_wr = permit_wr && req.wdata[wtf_pkg::BIT_RUNNING] && !running_q;
  wire logic stop_wr = permit_wr && !req.wdata[wtf_pkg::BIT_RUNNING];

  // ==========================================================
  // Counting datapath
  wire logic [15:0] reload_value_full = {reload_hi_q, reload_lo_q};
  wire logic [5:0] ratio = div_ratio(ctrl_q.input_clock_select);
  // Greater-or-equal so a ratio lowered mid-count wraps at the next edge
  wire logic div_wrap = (div_q >= ratio - 6'h01);
  wire logic count_tick = running_q && osc_edge && div_wrap;
  wire logic underflow = count_tick && (count_q == 16'h0000);
  // Card detection forces an immediate restart regardless of auto restart
  wire logic keep_going = ctrl_q.auto_reload_restart || ctrl_q.auto_card_detect;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 6'h00;
    end else if (start_wr || !running_q) begin
      div_q <= 6'h00;
    end else if (osc_edge) begin
      div_q <= div_wrap ? 6'h00 : div_q + 6'h01;
    end
  end

  // Reload bytes only reach the counter on a start or an underflow reload
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 16'h0000;
    end else if (start_wr || (underflow && keep_going)) begin
      count_q <= reload_value_full;
    end else if (count_tick && !underflow) begin
      count_q <= count_q - 16'h0001;
    end
  end

  a_reload_on_start: assert property (@(posedge clk) disable iff (!arst_n)
    start_wr
    |=> (count_q == $past(reload_value_full)))
    else $error("start did not load reload value");

  a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
    (count_tick && !underflow)
    |=> (count_q == $past(count_q) - 16'h0001))
    else $error("count did not step by one");

  a_count_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (running_q && !count_tick)
    |=> $stable(count_q))
    else $error("count moved without a tick");

  a_stopped_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (!running_q && !start_wr)
    |=> $stable(count_q))
    else $error("stopped count moved");

  a_reload_restart: assert property (@(posedge clk) disable iff (!arst_n)
    (underflow && keep_going)
    |=> (count_q == $past(reload_value_full)))
    else $error("underflow did not reload");

  a_reload_hold: assert property (@(posedge clk) disable iff (!arst_n)
    ((wr_rhi || wr_rlo) && running_q && !count_tick && !start_wr)
    |=> $stable(count_q))
    else $error("reload write disturbed count");

  a_count_read_only: assert property (@(posedge clk) disable iff (!arst_n)
    (req.wr && !count_tick &&
     (req.addr == wtf_pkg::ADDR_COUNT_HI || req.addr == wtf_pkg::ADDR_COUNT_LO))
    |=> $stable(count_q))
    else $error("count write changed count");

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      running_q <= 1'b0;
    end else if (start_wr) begin
      running_q <= 1'b1;
    end else if (stop_wr || (underflow && !keep_going)) begin
      running_q <= 1'b0;
    end
  end

  a_running_permit: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ctrl && !req.wdata[wtf_pkg::BIT_PERMIT] && !underflow)
    |=> $stable(running_q))
    else $error("running flag changed without permit");

  a_permit_start: assert property (@(posedge clk) disable iff (!arst_n)
    (permit_wr && req.wdata[wtf_pkg::BIT_RUNNING] && !underflow)
    |=> running_q)
    else $error("permitted start did not run");

  a_permit_stop: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ctrl && req.wdata[wtf_pkg::BIT_PERMIT] && !req.wdata[wtf_pkg::BIT_RUNNING])
    |=> !running_q)
    else $error("permitted stop did not halt");

  a_restart_no_gap: assert property (@(posedge clk) disable iff (!arst_n)
    (underflow && keep_going && !stop_wr)
    |=> running_q)
    else $error("timer did not restart");

  a_stop_at_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (underflow && !keep_going)
    |=> (!running_q && count_q == 16'h0000))
    else $error("timer did not stop at zero");

  // ==========================================================
  // Software-written registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= wtf_pkg::wtf_ctrl_t'(wtf_pkg::CONTROL_RST[5:0]);
      reload_hi_q <= wtf_pkg::RELOAD_RST;
      reload_lo_q <= wtf_pkg::RELOAD_RST;
      irq_mask_q <= wtf_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wtf_pkg::wtf_ctrl_t'(req.wdata[5:0]);
      end
      if (wr_rhi) begin
        reload_hi_q <= req.wdata;
      end
      if (wr_rlo) begin
        reload_lo_q <= req.wdata;
      end
      if (wr_mask) begin
        irq_mask_q <= req.wdata[wtf_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  a_ctrl_fields: assert property (@(posedge clk) disable iff (!arst_n)
    wr_ctrl
    |=> (6'(ctrl_q) == $past(req.wdata[5:0])))
    else $error("control fields not written");

  // ==========================================================
  // Card detection tracking and system requests
  wire logic card_start = underflow && ctrl_q.auto_card_detect;
  wire logic card_end = card_busy_q && card_detect_done;
  wire logic card_found = card_end && card_present;
  wire logic card_absent = card_end && !card_present;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      card_busy_q <= 1'b0;
    end else if (card_start) begin
      card_busy_q <= 1'b1;
    end else if (card_end) begin
      card_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_req <= '0;
      field_timer_start <= 1'b0;
    end else begin
      sys_req.trim_start <= underflow && ctrl_q.auto_osc_trim;
      sys_req.card_detect_start <= card_start;
      field_timer_start <= card_start;
      sys_req.wake <= underflow && ctrl_q.auto_wake_on_underflow;
      // Stay active when no wake is armed; power controller decides the rest
      sys_req.power_down <= card_absent && ctrl_q.auto_wake_on_underflow;
    end
  end

  a_trim_launch: assert property (@(posedge clk) disable iff (!arst_n)
    (underflow && ctrl_q.auto_osc_trim)
    |=> sys_req.trim_start)
    else $error("trim not launched");

  a_trim_source: assert property (@(posedge clk) disable iff (!arst_n)
    sys_req.trim_start
    |-> ($past(underflow) && $past(ctrl_q.auto_osc_trim)))
    else $error("trim without armed underflow");

  a_card_launch: assert property (@(posedge clk) disable iff (!arst_n)
    (underflow && ctrl_q.auto_card_detect)
    |=> (sys_req.card_detect_start && field_timer_start))
    else $error("card detection not launched");

  a_card_field: assert property (@(posedge clk) disable iff (!arst_n)
    field_timer_start
    |-> ($past(underflow) && $past(ctrl_q.auto_card_detect)))
    else $error("field window without card detect");

  a_power_down: assert property (@(posedge clk) disable iff (!arst_n)
    (card_absent && ctrl_q.auto_wake_on_underflow)
    |=> sys_req.power_down)
    else $error("no card did not power down");

  a_stay_active: assert property (@(posedge clk) disable iff (!arst_n)
    sys_req.power_down
    |-> $past(card_absent))
    else $error("power down without absent card");

  a_wake_launch: assert property (@(posedge clk) disable iff (!arst_n)
    sys_req.wake
    |-> $past(underflow))
    else $error("wake without underflow");

  a_wake_on_flow: assert property (@(posedge clk) disable iff (!arst_n)
    (underflow && ctrl_q.auto_wake_on_underflow)
    |=> sys_req.wake)
    else $error("underflow did not wake");

  a_wake_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    sys_req.wake
    |=> !sys_req.wake)
    else $error("wake request longer than one cycle");

  // ==========================================================
  // Interrupt status: set wins over write-one-to-clear
  wire logic [wtf_pkg::IRQ_WIDTH-1:0] irq_set = {card_absent, card_found, underflow};
  wire logic [wtf_pkg::IRQ_WIDTH-1:0] irq_clr =
    wr_stat ? req.wdata[wtf_pkg::IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  a_underflow_sets_irq: assert property (@(posedge clk) disable iff (!arst_n)
    underflow
    |=> irq_stat_q[wtf_pkg::IRQ_UNDERFLOW])
    else $error("underflow did not set flag");

  a_card_irq: assert property (@(posedge clk) disable iff (!arst_n)
    card_found
    |=> irq_stat_q[wtf_pkg::IRQ_CARD_FOUND])
    else $error("card found did not set flag");

  a_no_card_flag: assert property (@(posedge clk) disable iff (!arst_n)
    card_absent
    |=> irq_stat_q[wtf_pkg::IRQ_CARD_ABSENT])
    else $error("absent card did not set flag");

  a_w1c_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_stat && req.wdata[wtf_pkg::IRQ_UNDERFLOW] && !underflow)
    |=> !irq_stat_q[wtf_pkg::IRQ_UNDERFLOW])
    else $error("write one did not clear flag");

  // ==========================================================
  // Read mux, data one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    case (req.addr)
      wtf_pkg::ADDR_CONTROL: rd_mux = {running_q, 1'b0, ctrl_q};
      wtf_pkg::ADDR_RELOAD_HI: rd_mux = reload_hi_q;
      wtf_pkg::ADDR_RELOAD_LO: rd_mux = reload_lo_q;
      wtf_pkg::ADDR_COUNT_HI: rd_mux = count_q[15:8];
      wtf_pkg::ADDR_COUNT_LO: rd_mux = count_q[7:0];
      wtf_pkg::ADDR_IRQ_STATUS: rd_mux = {5'h00, irq_stat_q};
      wtf_pkg::ADDR_IRQ_MASK: rd_mux = {5'h00, irq_mask_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end

  a_read_running: assert property (@(posedge clk) disable iff (!arst_n)
    (req.rd && req.addr == wtf_pkg::ADDR_CONTROL)
    |=> (rdata[7] == $past(running_q)))
    else $error("running bit read wrong");

  a_read_bit6: assert property (@(posedge clk) disable iff (!arst_n)
    (req.rd && req.addr == wtf_pkg::ADDR_CONTROL)
    |=> !rdata[wtf_pkg::BIT_PERMIT])
    else $error("permit bit read back set");

  a_read_count_hi: assert property (@(posedge clk) disable iff (!arst_n)
    (req.rd && req.addr == wtf_pkg::ADDR_COUNT_HI)
    |=> (rdata == $past(count_q[15:8])))
    else $error("count high byte read wrong");

  a_read_count_lo: assert property (@(posedge clk) disable iff (!arst_n)
    (req.rd && req.addr == wtf_pkg::ADDR_COUNT_LO)
    |=> (rdata == $past(count_q[7:0])))
    else $error("count low byte read wrong");

  a_read_reload: assert property (@(posedge clk) disable iff (!arst_n)
    (req.rd && req.addr == wtf_pkg::ADDR_RELOAD_LO)
    |=> (rdata == $past(reload_lo_q)))
    else $error("reload low byte read wrong");

endmodule : wtf_wake_timer

// ### tb_wakeup_timer_four.sv
// Self-checking testbench for the wake-up timer block.
`timescale 1ns/1ps

module tb_wakeup_timer_four;
  // ==========================================================
  // Signals and register map aliases
  localparam logic [7:0] A_CTL = wtf_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_RHI = wtf_pkg::ADDR_RELOAD_HI;
  localparam logic [7:0] A_RLO = wtf_pkg::ADDR_RELOAD_LO;
  localparam logic [7:0] A_CHI = wtf_pkg::ADDR_COUNT_HI;
  localparam logic [7:0] A_CLO = wtf_pkg::ADDR_COUNT_LO;
  localparam logic [7:0] A_ST = wtf_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] A_MSK = wtf_pkg::ADDR_IRQ_MASK;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic osc_pin = 1'b0;
  wtf_pkg::wtf_req_t req = '0;
  logic cd_done = 1'b0;
  logic cd_present = 1'b0;
  logic [7:0] rdata;
  logic fts;
  wtf_pkg::wtf_sys_t sys;
  logic irq;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_trim = 0;
  int n_card = 0;
  int n_fts = 0;
  int n_wake = 0;
  int n_pd = 0;

  always #5 clk = ~clk;

  wtf_wake_timer dut (
    .clk(clk), .arst_n(arst_n), .osc_tick_async(osc_pin), .req(req), .rdata(rdata),
    .card_detect_done(cd_done), .card_present(cd_present), .field_timer_start(fts),
    .sys_req(sys), .irq(irq)
  );

  // ==========================================================
  // Pulse counting and hang guard
  // System requests are single-cycle, so count them every edge
  always @(posedge clk) begin
    cycles++;
    if (sys.trim_start === 1'b1) n_trim++;
    if (sys.card_detect_start === 1'b1) n_card++;
    if (sys.wake === 1'b1) n_wake++;
    if (sys.power_down === 1'b1) n_pd++;
    if (fts === 1'b1) n_fts++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Read data is only valid in the cycle after the strobe
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic r,
                     output logic [7:0] q);
    req <= '{addr: a, wdata: d, wr: ~r, rd: r};
    @(posedge clk);
    req <= '0;
    #1 q = rdata;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, d, 1'b0, q);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(a, 8'h00, 1'b1, q);
    chk(name, exp, q);
  endtask : rd

  task automatic irq_is(input logic e);
    #1 chk("irq", {7'h00, e}, {7'h00, irq});
    @(posedge clk);
  endtask : irq_is

  // Long enough to clear the two-flop synchroniser and the count update
  task automatic tick;
    osc_pin <= 1'b1;
    repeat (4) @(posedge clk);
    osc_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : tick

  task automatic cd_pulse(input logic present);
    cd_present <= present;
    cd_done <= 1'b1;
    @(posedge clk);
    cd_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : cd_pulse

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    rd("control", A_CTL, wtf_pkg::CONTROL_RST);
    rd("count_hi", A_CHI, 8'h00);
    rd("count_lo", A_CLO, 8'h00);
    rd("reload_lo", A_RLO, wtf_pkg::RELOAD_RST);
    wr(8'h40, 8'hFF);
    rd("unmapped", 8'h40, 8'h00);
    $display("test_reset finished");
  endtask : test_reset

  task automatic test_permit;
    wr(A_CTL, 8'h88);
    rd("control no permit", A_CTL, 8'h08);
    wr(A_CTL, 8'hC8);
    rd("control started", A_CTL, 8'h88);
    wr(A_CTL, 8'h08);
    rd("control kept", A_CTL, 8'h88);
    wr(A_CTL, 8'h40);
    rd("control stopped", A_CTL, 8'h00);
    $display("test_permit finished");
  endtask : test_permit

  task automatic test_countdown;
    wr(A_RHI, 8'h00);
    wr(A_RLO, 8'h02);
    wr(A_CTL, 8'hC8);
    rd("count_lo loaded", A_CLO, 8'h02);
    rd("count_hi loaded", A_CHI, 8'h00);
    tick();
    rd("count_lo step", A_CLO, 8'h01);
    wr(A_RLO, 8'h05);
    wr(A_CLO, 8'hFF);
    rd("count_lo undisturbed", A_CLO, 8'h01);
    tick();
    tick();
    rd("count_lo reloaded", A_CLO, 8'h05);
    rd("status underflow", A_ST, 8'h01);
    irq_is(1'b0);
    wr(A_MSK, 8'h01);
    irq_is(1'b1);
    wr(A_ST, 8'h01);
    irq_is(1'b0);
    wr(A_CTL, 8'h40);
    wr(A_MSK, 8'h00);
    $display("test_countdown finished");
  endtask : test_countdown

  task automatic test_oneshot;
    wr(A_RLO, 8'h01);
    wr(A_CTL, 8'hC0);
    tick();
    tick();
    rd("control halted", A_CTL, 8'h00);
    rd("count_lo at zero", A_CLO, 8'h00);
    rd("status oneshot", A_ST, 8'h01);
    wr(A_ST, 8'h01);
    $display("test_oneshot finished");
  endtask : test_oneshot

  task automatic test_system;
    wr(A_RLO, 8'h00);
    wr(A_CTL, 8'hF4);
    tick();
    chk("trim pulses", 8'h01, 8'(n_trim));
    chk("card pulses", 8'h01, 8'(n_card));
    chk("field timer pulses", 8'h01, 8'(n_fts));
    chk("wake pulses", 8'h01, 8'(n_wake));
    rd("control still running", A_CTL, 8'hB4);
    cd_pulse(1'b0);
    rd("status no card", A_ST, 8'h05);
    chk("power down pulses", 8'h01, 8'(n_pd));
    // Detection result only counts after a fresh launch
    tick();
    chk("card pulses again", 8'h02, 8'(n_card));
    cd_pulse(1'b1);
    rd("status card found", A_ST, 8'h07);
    chk("power down unchanged", 8'h01, 8'(n_pd));
    wr(A_ST, 8'h07);
    wr(A_CTL, 8'h40);
    $display("test_system finished");
  endtask : test_system

  task automatic test_clksel;
    int ratio;
    for (int c = 0; c < 4; c++) begin
      ratio = (c == 0) ? 1 : (4 << c);
      wr(A_RLO, 8'h10);
      wr(A_CTL, 8'h08 | 8'(c));
      wr(A_CTL, 8'hC8 | 8'(c));
      repeat (ratio - 1) tick();
      rd("count before wrap", A_CLO, 8'h10);
      tick();
      rd("count after wrap", A_CLO, 8'h0F);
      wr(A_CTL, 8'h40);
    end
    $display("test_clksel finished");
  endtask : test_clksel

  task automatic test_midreset;
    wr(A_RLO, 8'h03);
    wr(A_CTL, 8'hCC);
    tick();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd("control after reset", A_CTL, wtf_pkg::CONTROL_RST);
    rd("reload after reset", A_RLO, wtf_pkg::RELOAD_RST);
    rd("count after reset", A_CLO, 8'h00);
    $display("test_midreset finished");
  endtask : test_midreset

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    test_reset();
    test_permit();
    test_countdown();
    test_oneshot();
    test_system();
    test_clksel();
    test_midreset();
    stop_test();
  end
endmodule : tb_wakeup_timer_four
